// >>> rtl/alu_defs.svh
// instruction field positions and opcode values for the arithmetic and logic unit
`ifndef ALU_DEFS_SVH
`define ALU_DEFS_SVH

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define ALU_TOP_HI      15
`define ALU_TOP_LO      14
`define ALU_GRP_HI      13
`define ALU_GRP_LO      11
`define ALU_FN_HI       10
`define ALU_FN_LO       8
`define ALU_SRC_HI      7
`define ALU_SRC_LO      4
`define ALU_DST_HI      3
`define ALU_DST_LO      0
`define ALU_IMM_HI      11
`define ALU_IMM_LO      4

// ----------------------------------------------------------------------
// opcode values
// ----------------------------------------------------------------------
`define ALU_TOP_IMM     2'h2
`define ALU_TOP_REG     2'h3
`define ALU_IMM_SUM     2'h0
`define ALU_IMM_CMP     2'h1
`define ALU_GRP_CMP     3'h5
`define ALU_GRP_WORD    3'h2
`define ALU_GRP_NARROW  3'h3
`define ALU_GRP_LOGIC   3'h4
`define ALU_FN_CMP      3'h3
`define ALU_FN_CARRY    3'h6
`define ALU_FN_COMPARE_CHAINED     3'h7

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define ALU_FLAG_RST    1'h0
`define ALU_WORD_RST    16'h0000
`define ALU_ADDR_RST    4'h0

`endif

// >>> rtl/alu_pkg.sv
// types shared by the arithmetic and logic unit files
package alu_pkg;

  // ----------------------------------------------------------------------
  // operation class chosen by the decoder
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ALU_OP_NONE   = 3'b000,  // not for this unit
    ALU_OP_IMM    = 3'b001,  // immediate sum or compare
    ALU_OP_CMP    = 3'b010,  // register compare, plain or chained
    ALU_OP_CARRY  = 3'b011,  // carry force high or low
    ALU_OP_WORD   = 3'b100,  // 16-bit register arithmetic
    ALU_OP_BYTE   = 3'b101,  // low byte arithmetic
    ALU_OP_NIBBLE = 3'b110,  // low nibble arithmetic
    ALU_OP_LOGIC  = 3'b111   // logic and bit operations
  } alu_op_t;

endpackage : alu_pkg

// >>> rtl/alu_adder.sv
// parameterised adder and subtractor with carry, borrow and overflow
`timescale 1ns/1ps
`default_nettype none

module alu_adder #(
  parameter int W = 16
) (
  // operands
  input  wire logic [W-1:0] i_a,
  input  wire logic [W-1:0] i_b,
  input  wire logic         i_cin,
  input  wire logic         i_sub,
  // results
  output logic      [W-1:0] o_sum,
  output logic              o_cout,
  output logic              o_ovf
);

  // ----------------------------------------------------------------------
  // one wider sum; on subtract the top bit is the borrow
  // ----------------------------------------------------------------------
  logic [W:0] wide;  // sum with carry bit

  assign wide   = i_sub ? ({1'b0, i_a} - {1'b0, i_b} - {{W{1'b0}}, i_cin})
                        : ({1'b0, i_a} + {1'b0, i_b} + {{W{1'b0}}, i_cin});
  assign o_sum  = wide[W-1:0];
  assign o_cout = wide[W];
  // signed overflow: operand signs versus result sign
  assign o_ovf  = i_sub ? ((i_a[W-1] != i_b[W-1]) && (wide[W-1] != i_a[W-1]))
                        : ((i_a[W-1] == i_b[W-1]) && (wide[W-1] != i_a[W-1]));

endmodule : alu_adder

`default_nettype wire

// >>> rtl/alu_logic.sv
// bitwise logic and single bit operations on a 16-bit word
`timescale 1ns/1ps
`default_nettype none

module alu_logic (
  // operands
  input  wire logic [15:0] i_dst,
  input  wire logic [15:0] i_src,
  input  wire logic [3:0]  i_field,
  input  wire logic [2:0]  i_fn,
  // result
  output logic      [15:0] o_res
);

  // ----------------------------------------------------------------------
  // masks built from the four bit field
  // ----------------------------------------------------------------------
  logic [15:0] bit_sel;   // one hot selected bit
  logic [15:0] low_keep;  // ones below the field value

  assign bit_sel  = 16'h0001 << i_field;
  assign low_keep = bit_sel - 16'h0001;

  // ----------------------------------------------------------------------
  // function select
  // ----------------------------------------------------------------------
  assign o_res = (i_fn == 3'h0) ? ~i_src :
                 (i_fn == 3'h1) ? (i_dst & i_src) :
                 (i_fn == 3'h2) ? (i_dst | i_src) :
                 (i_fn == 3'h3) ? (i_dst ^ i_src) :
                 (i_fn == 3'h4) ? (i_dst & low_keep) :
                 (i_fn == 3'h5) ? (i_dst & ~bit_sel) :
                 (i_fn == 3'h6) ? (i_dst | bit_sel) :
                                  (i_dst ^ bit_sel);

endmodule : alu_logic

`default_nettype wire

// >>> rtl/alu_unit.sv
// arithmetic and logic execution unit of the 16-bit soft processor
//
// Overview of operation
// - flags change on 16-bit arithmetic, not narrower
// - immediate sum adds sign-extended 8-bit constant
// - wide immediates are prefix plus immediate instruction
// - prefix byte replaces sign-extended constant upper byte
// - immediate compare subtracts, sets zero/carry, no write
// - carry force high sets, low clears carry
// - register compare subtracts, sets zero/carry, no write
// - chained compare includes incoming carry
// - copy and two's-complement copy, flags updated
// - chained copies include carry; aliases use equal fields
// - register add and subtract write destination
// - carry and borrow forms include incoming carry
// - byte copy and byte complement copy, flags kept
// - byte sum/difference on low byte only
// - nibble operations keep upper twelve bits
// - word arithmetic function codes in bits 10-8
// - logic takes two words or one bit
// - logical function codes, field and destination positions
// - not writes one's complement of source
// - and, or, xor write bitwise result
// - keep low bits zeroes the count bit and all above
// - force bit zero, one, or toggle one bit
`include "alu_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module alu_unit (
  // clock and reset
  input  wire logic        I_CLK,
  input  wire logic        I_RST,
  // instruction from the decoder
  input  wire logic        I_INSTR_VALID,
  input  wire logic [15:0] I_INSTR,
  // operands from the register file
  input  wire logic [15:0] I_DST_DATA,
  input  wire logic [15:0] I_SRC_DATA,
  // upper byte prefix register
  input  wire logic        I_PREFIX_VALID,
  input  wire logic [7:0]  I_PREFIX_BYTE,
  // register write back
  output logic             O_WR_EN,
  output logic      [3:0]  O_WR_ADDR,
  output logic      [15:0] O_WR_DATA,
  // condition flags
  output logic             O_CARRY,
  output logic             O_OVERFLOW,
  output logic             O_ZERO
);

  // ----------------------------------------------------------------------
  // instruction fields
  // ----------------------------------------------------------------------
  logic [1:0]  f_top;   // bits 15-14
  logic [1:0]  f_isub;  // bits 13-12 of immediate form
  logic [2:0]  f_grp;   // bits 13-11
  logic [2:0]  f_fn;    // bits 10-8
  logic [3:0]  f_src;   // source or bit field
  logic [3:0]  f_dst;   // destination index
  logic [7:0]  f_imm;   // 8-bit constant

  assign f_top  = I_INSTR[`ALU_TOP_HI:`ALU_TOP_LO];
  assign f_isub = I_INSTR[`ALU_GRP_HI:`ALU_GRP_HI-1];
  assign f_grp  = I_INSTR[`ALU_GRP_HI:`ALU_GRP_LO];
  assign f_fn   = I_INSTR[`ALU_FN_HI:`ALU_FN_LO];
  assign f_src  = I_INSTR[`ALU_SRC_HI:`ALU_SRC_LO];
  assign f_dst  = I_INSTR[`ALU_DST_HI:`ALU_DST_LO];
  assign f_imm  = I_INSTR[`ALU_IMM_HI:`ALU_IMM_LO];

  // ----------------------------------------------------------------------
  // operation class decode
  // ----------------------------------------------------------------------
  logic              is_imm;     // immediate sum or compare
  logic              is_imm_cmp; // immediate compare
  alu_pkg::alu_op_t  op;         // decoded class

  assign is_imm     = I_INSTR_VALID && (f_top == `ALU_TOP_IMM)
                      && (f_isub == `ALU_IMM_SUM || f_isub == `ALU_IMM_CMP);
  assign is_imm_cmp = (f_isub == `ALU_IMM_CMP);

  assign op =
    !I_INSTR_VALID ? alu_pkg::ALU_OP_NONE :
    is_imm ? alu_pkg::ALU_OP_IMM :
    (f_top == `ALU_TOP_IMM && f_grp == `ALU_GRP_CMP
      && (f_fn == `ALU_FN_CMP || f_fn == `ALU_FN_COMPARE_CHAINED)) ? alu_pkg::ALU_OP_CMP :
    (f_top == `ALU_TOP_IMM && f_grp == `ALU_GRP_CMP
      && f_fn == `ALU_FN_CARRY) ? alu_pkg::ALU_OP_CARRY :
    (f_top == `ALU_TOP_REG && f_grp == `ALU_GRP_WORD)
      ? alu_pkg::ALU_OP_WORD :
    (f_top == `ALU_TOP_REG && f_grp == `ALU_GRP_NARROW && !f_fn[2])
      ? alu_pkg::ALU_OP_BYTE :
    (f_top == `ALU_TOP_REG && f_grp == `ALU_GRP_NARROW && f_fn[2])
      ? alu_pkg::ALU_OP_NIBBLE :
    (f_top == `ALU_TOP_REG && f_grp == `ALU_GRP_LOGIC)
      ? alu_pkg::ALU_OP_LOGIC :
      alu_pkg::ALU_OP_NONE;

  // ----------------------------------------------------------------------
  // immediate constant: prefix byte or sign extension on top
  // ----------------------------------------------------------------------
  logic [15:0] imm_word;  // 16-bit constant

  assign imm_word = I_PREFIX_VALID ? {I_PREFIX_BYTE, f_imm}
                                   : {{8{f_imm[7]}}, f_imm};

  // ----------------------------------------------------------------------
  // 16-bit adder operand select
  // ----------------------------------------------------------------------
  logic        word_form;  // register word arithmetic
  logic [15:0] w_a;        // first operand
  logic [15:0] w_b;        // second operand
  logic        w_cin;      // incoming carry
  logic        w_sub;      // subtract
  logic [15:0] w_sum;      // result
  logic        w_cout;     // carry or borrow out
  logic        w_ovf;      // signed overflow

  assign word_form = (op == alu_pkg::ALU_OP_WORD);
  // copies use zero as first operand; add/sub use destination
  assign w_a   = (word_form && !f_fn[1]) ? 16'h0000 : I_DST_DATA;
  assign w_b   = (op == alu_pkg::ALU_OP_IMM) ? imm_word : I_SRC_DATA;
  assign w_sub = (op == alu_pkg::ALU_OP_IMM) ? is_imm_cmp :
                 (op == alu_pkg::ALU_OP_CMP) ? 1'b1 : f_fn[0];
  assign w_cin = ((word_form && f_fn[2])
                  || (op == alu_pkg::ALU_OP_CMP && f_fn == `ALU_FN_COMPARE_CHAINED)) ? O_CARRY
                                                                   : 1'b0;

  alu_adder #(
    .W (16)
  ) u_word (
    .i_a    (w_a),
    .i_b    (w_b),
    .i_cin  (w_cin),
    .i_sub  (w_sub),
    .o_sum  (w_sum),
    .o_cout (w_cout),
    .o_ovf  (w_ovf)
  );

  // ----------------------------------------------------------------------
  // byte and nibble adders, no flags
  // ----------------------------------------------------------------------
  logic [7:0] b_a;    // byte first operand, zero for copies
  logic [3:0] n_a;    // nibble first operand, zero for copies
  logic [7:0] b_sum;  // byte result
  logic [3:0] n_sum;  // nibble result

  // copies and complement copies start from zero, sums from the destination
  assign b_a = f_fn[1] ? I_DST_DATA[7:0] : 8'h00;
  assign n_a = f_fn[1] ? I_DST_DATA[3:0] : 4'h0;

  alu_adder #(
    .W (8)
  ) u_byte (
    .i_a    (b_a),
    .i_b    (I_SRC_DATA[7:0]),
    .i_cin  (1'b0),
    .i_sub  (f_fn[0]),
    .o_sum  (b_sum),
    .o_cout (),
    .o_ovf  ()
  );

  alu_adder #(
    .W (4)
  ) u_nibble (
    .i_a    (n_a),
    .i_b    (I_SRC_DATA[3:0]),
    .i_cin  (1'b0),
    .i_sub  (f_fn[0]),
    .o_sum  (n_sum),
    .o_cout (),
    .o_ovf  ()
  );

  // ----------------------------------------------------------------------
  // logic unit
  // ----------------------------------------------------------------------
  logic [15:0] l_res;  // logic result

  alu_logic u_logic (
    .i_dst   (I_DST_DATA),
    .i_src   (I_SRC_DATA),
    .i_field (f_src),
    .i_fn    (f_fn),
    .o_res   (l_res)
  );

  // ----------------------------------------------------------------------
  // write back and flag selection
  // ----------------------------------------------------------------------
  logic        flag_word;  // all three flags from the word adder
  logic        flag_cmp;   // zero and carry only
  logic        next_wr_en;
  logic [15:0] next_wr_data;
  logic        next_carry;
  logic        next_overflow;
  logic        next_zero;

  assign flag_word = (op == alu_pkg::ALU_OP_WORD)
                     || (op == alu_pkg::ALU_OP_IMM && !is_imm_cmp);
  assign flag_cmp  = (op == alu_pkg::ALU_OP_CMP)
                     || (op == alu_pkg::ALU_OP_IMM && is_imm_cmp);

  // compares and carry forcing write no register
  assign next_wr_en = (op == alu_pkg::ALU_OP_WORD) || (op == alu_pkg::ALU_OP_BYTE)
                      || (op == alu_pkg::ALU_OP_NIBBLE) || (op == alu_pkg::ALU_OP_LOGIC)
                      || (op == alu_pkg::ALU_OP_IMM && !is_imm_cmp);

  assign next_wr_data =
    (op == alu_pkg::ALU_OP_BYTE)   ? {I_DST_DATA[15:8], b_sum} :
    (op == alu_pkg::ALU_OP_NIBBLE) ? {I_DST_DATA[15:4], n_sum} :
    (op == alu_pkg::ALU_OP_LOGIC)  ? l_res : w_sum;

  assign next_carry    = (flag_word || flag_cmp) ? w_cout :
                         (op == alu_pkg::ALU_OP_CARRY) ? f_src[0] : O_CARRY;
  assign next_overflow = flag_word ? w_ovf : O_OVERFLOW;
  assign next_zero     = (flag_word || flag_cmp) ? (w_sum == 16'h0000) : O_ZERO;

  // ----------------------------------------------------------------------
  // output registers, one cycle after the instruction
  // ----------------------------------------------------------------------
  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      O_WR_EN    <= 1'b0;
      O_WR_ADDR  <= `ALU_ADDR_RST;
      O_WR_DATA  <= `ALU_WORD_RST;
      O_CARRY    <= `ALU_FLAG_RST;
      O_OVERFLOW <= `ALU_FLAG_RST;
      O_ZERO     <= `ALU_FLAG_RST;
    end
    else
    begin
      O_WR_EN    <= next_wr_en;
      O_WR_ADDR  <= f_dst;
      O_WR_DATA  <= next_wr_data;
      O_CARRY    <= next_carry;
      O_OVERFLOW <= next_overflow;
      O_ZERO     <= next_zero;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  property p_narrow_flags;
    @(posedge I_CLK) disable iff (I_RST)
    (op == alu_pkg::ALU_OP_BYTE || op == alu_pkg::ALU_OP_NIBBLE)
      |=> $stable({O_CARRY, O_OVERFLOW, O_ZERO});
  endproperty
  a_narrow_flags: assert property (p_narrow_flags)
    else $error("narrow arithmetic changed a flag");

  property p_imm_sum;
    @(posedge I_CLK) disable iff (I_RST)
    (op == alu_pkg::ALU_OP_IMM && !is_imm_cmp && !I_PREFIX_VALID)
      |=> O_WR_EN && O_WR_DATA == $past(I_DST_DATA) + {{8{$past(f_imm[7])}}, $past(f_imm)};
  endproperty
  a_imm_sum: assert property (p_imm_sum)
    else $error("immediate sum result wrong");

  property p_prefix;
    @(posedge I_CLK) disable iff (I_RST)
    (op == alu_pkg::ALU_OP_IMM && !is_imm_cmp && I_PREFIX_VALID)
      |=> O_WR_DATA == $past(I_DST_DATA) + {$past(I_PREFIX_BYTE), $past(f_imm)};
  endproperty
  a_prefix: assert property (p_prefix)
    else $error("prefix byte not used as upper constant byte");

  property p_cmp_nowrite;
    @(posedge I_CLK) disable iff (I_RST)
    (op == alu_pkg::ALU_OP_CMP || op == alu_pkg::ALU_OP_CARRY || (is_imm && is_imm_cmp))
      |=> !O_WR_EN && $stable(O_OVERFLOW);
  endproperty
  a_cmp_nowrite: assert property (p_cmp_nowrite)
    else $error("compare wrote a register or overflow");

  property p_cmp_zero;
    @(posedge I_CLK) disable iff (I_RST)
    (op == alu_pkg::ALU_OP_CMP && f_fn == `ALU_FN_CMP)
      |=> O_ZERO == ($past(I_DST_DATA) == $past(I_SRC_DATA))
          && O_CARRY == ($past(I_DST_DATA) < $past(I_SRC_DATA));
  endproperty
  a_cmp_zero: assert property (p_cmp_zero)
    else $error("register compare flags wrong");

  property p_carry_force;
    @(posedge I_CLK) disable iff (I_RST)
    (op == alu_pkg::ALU_OP_CARRY) |=> O_CARRY == $past(f_src[0]) && !O_WR_EN;
  endproperty
  a_carry_force: assert property (p_carry_force)
    else $error("carry force wrong");

  property p_byte_upper;
    @(posedge I_CLK) disable iff (I_RST)
    (op == alu_pkg::ALU_OP_BYTE) |=> O_WR_DATA[15:8] == $past(I_DST_DATA[15:8]);
  endproperty
  a_byte_upper: assert property (p_byte_upper)
    else $error("byte operation changed upper byte");

  property p_logic_flags;
    @(posedge I_CLK) disable iff (I_RST)
    (op == alu_pkg::ALU_OP_LOGIC)
      |=> O_WR_EN && $stable({O_CARRY, O_OVERFLOW, O_ZERO});
  endproperty
  a_logic_flags: assert property (p_logic_flags)
    else $error("logic operation changed a flag");

  property p_add;
    @(posedge I_CLK) disable iff (I_RST)
    (op == alu_pkg::ALU_OP_WORD && f_fn == 3'h2)
      |=> O_WR_DATA == $past(I_DST_DATA) + $past(I_SRC_DATA)
          && O_WR_ADDR == $past(f_dst);
  endproperty
  a_add: assert property (p_add)
    else $error("register add result wrong");

  // immediate compare: borrow and zero from dst minus constant, no write
  property p_imm_cmp;
    @(posedge I_CLK) disable iff (I_RST)
    (op == alu_pkg::ALU_OP_IMM && is_imm_cmp)
      |=> !O_WR_EN && O_ZERO == ($past(I_DST_DATA) == $past(imm_word))
          && O_CARRY == ($past(I_DST_DATA) < $past(imm_word));
  endproperty
  a_imm_cmp: assert property (p_imm_cmp)
    else $error("immediate compare flags or write wrong");

  // plain copy: source passes through, it can neither carry nor overflow
  property p_word_copy;
    @(posedge I_CLK) disable iff (I_RST)
    (op == alu_pkg::ALU_OP_WORD && f_fn == 3'h0)
      |=> O_WR_EN && O_WR_DATA == $past(I_SRC_DATA) && !O_CARRY && !O_OVERFLOW
          && O_ZERO == ($past(I_SRC_DATA) == 16'h0000);
  endproperty
  a_word_copy: assert property (p_word_copy)
    else $error("register copy result or flags wrong");

  // add with carry takes the flag left by the previous instruction
  property p_sum_carry;
    @(posedge I_CLK) disable iff (I_RST)
    (op == alu_pkg::ALU_OP_WORD && f_fn == 3'h6)
      |=> O_WR_DATA == $past(I_DST_DATA) + $past(I_SRC_DATA) + {15'h0000, $past(O_CARRY)};
  endproperty
  a_sum_carry: assert property (p_sum_carry)
    else $error("add with carry result wrong");

  // nibble operations must keep the upper twelve bits
  property p_nibble_upper;
    @(posedge I_CLK) disable iff (I_RST)
    (op == alu_pkg::ALU_OP_NIBBLE)
      |=> O_WR_EN && O_WR_DATA[15:4] == $past(I_DST_DATA[15:4]);
  endproperty
  a_nibble_upper: assert property (p_nibble_upper)
    else $error("nibble operation changed upper bits");

endmodule : alu_unit

`default_nettype wire

// >>> verification/alu_regfile_model.sv
// register file model facing the unit: operand reads and write back
`timescale 1ns/1ps
`default_nettype none

module alu_regfile_model (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // read indexes from the instruction
  input  wire logic [3:0]  i_dst_addr,
  input  wire logic [3:0]  i_src_addr,
  // write back from the unit
  input  wire logic        i_wr_en,
  input  wire logic [3:0]  i_wr_addr,
  input  wire logic [15:0] i_wr_data,
  // operands to the unit
  output logic      [15:0] o_dst_data,
  output logic      [15:0] o_src_data
);
  logic [15:0] regs [16];  // sixteen general registers

  // forward a write in flight so back to back chains see fresh data
  assign o_dst_data = (i_wr_en && i_wr_addr == i_dst_addr) ? i_wr_data : regs[i_dst_addr];
  assign o_src_data = (i_wr_en && i_wr_addr == i_src_addr) ? i_wr_data : regs[i_src_addr];

  // registers clear on reset, take write back otherwise
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      regs <= '{default: 16'h0000};
    else if (i_wr_en)
      regs[i_wr_addr] <= i_wr_data;
  end
endmodule : alu_regfile_model

`default_nettype wire

// >>> verification/alu_unit_test.sv
// self-checking random bench for the arithmetic and logic unit
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin bad_count++; $display("unexpected %s expected %h seen %h", nm, e, g); end end

module alu_unit_test;
  // ----------------------------------------------------------------------
  // signals and shadow state
  // ----------------------------------------------------------------------
  logic        clk;        // 125 MHz clock
  logic        rst;        // synchronous reset
  logic        valid;      // instruction present
  logic [15:0] instr;      // instruction word
  logic        pre_valid;  // prefix held
  logic [7:0]  pre_byte;   // prefix byte
  wire  logic [15:0] dst_data;
  wire  logic [15:0] src_data;
  wire  logic        wr_en;
  wire  logic [3:0]  wr_addr;
  wire  logic [15:0] wr_data;
  wire  logic        carry;
  wire  logic        ovf;
  wire  logic        zero;
  int          bad_count;
  int          checked;
  int          cycles;
  int          seed;
  logic [15:0] sreg [16];  // expected register contents
  logic        fc, fv, fz; // expected flags
  logic        e_en;       // expected write strobe
  logic        have_pend;  // a result is due
  logic [3:0]  e_addr;
  logic [15:0] ed;
  logic [1:0]  ec;         // class: imm, word, narrow, logic
  // directed corner cases: {prefix valid, instruction}
  localparam logic [16:0] DIR_LIST [19] = '{17'h0_ae10, 17'h0_ae00, 17'h0_8ff1, 17'h0_d211,
    17'h0_d622, 17'h0_ab21, 17'h0_af21, 17'h1_9341, 17'h1_80a3, 17'h0_e401, 17'h0_e4f3,
    17'h0_e7f1, 17'h0_e501, 17'h0_e6f2, 17'h0_da21, 17'h0_df21, 17'h0_d111, 17'h0_0123,
    17'h0_ad21};

  alu_unit alu_unit_i (.I_CLK(clk), .I_RST(rst), .I_INSTR_VALID(valid), .I_INSTR(instr),
    .I_DST_DATA(dst_data), .I_SRC_DATA(src_data), .I_PREFIX_VALID(pre_valid),
    .I_PREFIX_BYTE(pre_byte), .O_WR_EN(wr_en), .O_WR_ADDR(wr_addr), .O_WR_DATA(wr_data),
    .O_CARRY(carry), .O_OVERFLOW(ovf), .O_ZERO(zero));

  alu_regfile_model alu_regfile_model_i (.i_clk(clk), .i_rst(rst), .i_dst_addr(instr[3:0]),
    .i_src_addr(instr[7:4]), .i_wr_en(wr_en), .i_wr_addr(wr_addr), .i_wr_data(wr_data),
    .o_dst_data(dst_data), .o_src_data(src_data));

  // clock and hang guard
  always #4 clk = ~clk;
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      bad_count++;
      final_report();
    end
  end

  // ----------------------------------------------------------------------
  // expectation functions
  // ----------------------------------------------------------------------
  // returns {carry or borrow, overflow, zero, result}
  function automatic logic [18:0] arith(input logic [15:0] a, input logic [15:0] b,
                                        input logic ci, input logic sb);
    logic [16:0] u;
    logic [16:0] sx;
    u  = sb ? {1'b0, a} - {1'b0, b} - 17'(ci) : {1'b0, a} + {1'b0, b} + 17'(ci);
    sx = sb ? {a[15], a} - {b[15], b} - 17'(ci) : {a[15], a} + {b[15], b} + 17'(ci);
    return {u[16], sx[16] ^ sx[15], u[15:0] == 16'h0000, u[15:0]};
  endfunction : arith

  // logic group result, n is the bit or count field
  function automatic logic [15:0] logic_res(input logic [15:0] d, input logic [15:0] s,
                                            input logic [2:0] fn, input logic [3:0] n);
    logic [15:0] m;
    m = 16'h0001 << n;
    case (fn)
      3'h0: return ~s;
      3'h1: return d & s;
      3'h2: return d | s;
      3'h3: return d ^ s;
      3'h4: return d & (m - 16'h0001);
      3'h5: return d & ~m;
      3'h6: return d | m;
      default: return d ^ m;
    endcase
  endfunction : logic_res

  // works out the outcome of one instruction and advances the shadow state
  task automatic model(input logic [15:0] ins, input logic pv, input logic [7:0] pb);
    logic [15:0] d, s, k, a, x, y, t;
    logic [2:0]  fn;
    logic        ci, sb;
    logic [1:0]  fm;
    logic [18:0] r;
    d = sreg[ins[3:0]];
    s = sreg[ins[7:4]];
    fn = ins[10:8];
    k = pv ? {pb, ins[11:4]} : {{8{ins[11]}}, ins[11:4]};
    a = fn[1] ? d : 16'h0000;
    {x, y, ci, sb, fm, e_en, ec} = '0;
    e_addr = ins[3:0];
    casez (ins[15:11])
      5'b1000?: {x, y, fm, e_en} = {d, k, 2'd2, 1'b1};
      5'b1001?: {x, y, sb, fm} = {d, k, 1'b1, 2'd1};
      5'b10101: {x, y, ci, sb, fm} = {d, s, fn[2] & fc, 1'b1, 1'b0, fn[1] & fn[0]};
      5'b11010: {x, y, ci, sb, fm, e_en, ec} = {a, s, fn[2] & fc, fn[0], 2'd2, 1'b1, 2'd1};
      5'b11011: {e_en, ec} = {1'b1, 2'd2};
      5'b11100: {e_en, ec} = {1'b1, 2'd3};
      default: ;
    endcase
    r = arith(x, y, ci, sb);
    t = fn[0] ? a - s : a + s;
    ed = r[15:0];
    if (ec == 2'd2)
      ed = fn[2] ? {d[15:4], t[3:0]} : {d[15:8], t[7:0]};
    if (ec == 2'd3)
      ed = logic_res(d, s, fn, ins[7:4]);
    if (fm == 2'd2)
      {fc, fv, fz} = r[18:16];
    if (fm == 2'd1)
      {fc, fz} = {r[18], r[16]};
    if (ins[15:8] == 8'hae)
      fc = ins[4];
    if (e_en)
      sreg[ins[3:0]] = ed;
  endtask : model

  // ----------------------------------------------------------------------
  // drivers
  // ----------------------------------------------------------------------
  // checks the result due at this edge, then presents the next instruction
  task automatic step(input logic v, input logic [15:0] ins, input logic pv,
                      input logic [7:0] pb);
    @(posedge clk);
    #1;
    if (have_pend)
    begin
      `CHK("wr_en", e_en, wr_en)
      if (e_en)
      begin
        `CHK("wr_addr", e_addr, wr_addr)
        if (ec == 0) `CHK("imm", ed, wr_data)
        if (ec == 1) `CHK("word", ed, wr_data)
        if (ec == 2) `CHK("narrow", ed, wr_data)
        if (ec == 3) `CHK("logic", ed, wr_data)
      end
      `CHK("carry", fc, carry)
      `CHK("overflow", fv, ovf)
      `CHK("zero", fz, zero)
    end
    valid = v;
    instr = ins;
    pre_valid = pv;
    pre_byte = pb;
    #1;
    `CHK("dst_operand", sreg[ins[3:0]], dst_data)
    if (v)
      model(ins, pv, pb);
    else
      e_en = 1'b0;
    have_pend = 1'b1;
  endtask : step

  // one random instruction drawn from the decodable groups and a refused one
  task automatic rand_step;
    logic [31:0] q;
    logic [15:0] ins;
    q = $random(seed);
    case (q[2:0])
      3'd0: ins = {4'h8, q[27:16]};
      3'd1: ins = {4'h9, q[27:16]};
      3'd2: ins = {5'b10101, q[28] ? 3'h7 : 3'h3, q[23:16]};
      3'd3: ins = {8'hae, 3'h0, q[16], q[19:16]};
      3'd6: ins = {5'b11011, q[26:16]};
      3'd7: ins = q[28] ? {5'b11100, q[26:16]} : {2'b00, q[29:16]};
      default: ins = {5'b11010, q[26:16]};
    endcase
    step(q[6:4] != 3'h0, ins, q[3], q[15:8]);
  endtask : rand_step

  // reset held for twelve cycles, shadow cleared to match
  task automatic do_reset;
    @(posedge clk);
    #1;
    rst = 1'b1;
    valid = 1'b0;
    repeat (12) @(posedge clk);
    #1;
    rst = 1'b0;
    foreach (sreg[i]) sreg[i] = 16'h0000;
    {fc, fv, fz, e_en} = 4'h0;
    have_pend = 1'b1;
  endtask : do_reset

  // verdict and end of run
  task automatic final_report;
    if (bad_count == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report

  // ----------------------------------------------------------------------
  // main sequence: two runs, the second after a mid-run reset
  // ----------------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    valid = 1'b0;
    instr = 16'h0000;
    pre_valid = 1'b0;
    pre_byte = 8'h00;
    bad_count = 0;
    checked = 0;
    cycles = 0;
    have_pend = 1'b0;
    seed = 32'hd3ae_e048;
    for (int p = 0; p < 2; p++)
    begin
      do_reset();
      foreach (DIR_LIST[i]) step(1'b1, DIR_LIST[i][15:0], DIR_LIST[i][16], 8'hc3);
      repeat (1500) rand_step();
    end
    step(1'b0, 16'h0000, 1'b0, 8'h00);
    final_report();
  end
endmodule : alu_unit_test

`default_nettype wire
